// [design/tcr_timer.sv]
// Sixteen-bit capture/reload timer with APB register access.
// Assumes one 25 MHz clock; pins arrive unsynchronised.
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "tcr_consts.svh"

// What this block does
// - Count is two cascaded bytes; low byte rollover carries into high byte.
// - Overflow flag holds until software clears it, else clears on vectoring.
// - External flag holds until software clears it, else clears on vectoring.
// - Two-bit prescale field in mode register sets internal count rate.
// - Clock-out drives the count pin only while output enable is set.
// - Reset clears down-count enable; setting it in auto-reload mode gives up/down counting.
// - Serial-select picks which serial port gets the baud clock.
// - Mode from serial-select, then capture-select and output enable.
// - Overflow sets overflow flag in every mode except baud generator.
// - External enable lets trigger falling edge capture or reload.
// - Counter/timer select picks prescaled clock or count pin falls.
// - Count advances only while run control is set.
// - Capture mode trigger fall copies count to capture pair, sets flag.
// - Capture/reload select is ignored while serving as baud clock.
// - Auto-reload up count overflows at FFFF, sets flag, reloads.
// - Up auto-reload with external enable: trigger fall reloads, sets flag.
// - Down-count enabled in auto-reload: trigger level high counts up, low counts down.
// - Down count underflows at reload value, sets flag, loads FFFF.
// - Up/down mode toggles external flag per wrap; no interrupt from it.
// - Interrupt request when either flag is set, with up/down and clock-out exceptions.
// - Internal rate is once per one to four state times of three clocks.
// - Baud mode high byte rollover reloads both bytes from reload pair.
// - Baud mode trigger fall sets external flag but never reloads.
// - Clock-out overflows toggle a divide-by-two pin, no interrupt.
module tcr_timer
    import tcr_pkg::*;
(
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RST,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // Count pin, two-way
    input  wire logic        COUNT_PIN_IN,
    output logic             COUNT_PIN_OUT,
    output logic             COUNT_PIN_OE_N,
    // Trigger pin
    input  wire logic        TRIGGER_PIN,
    // Interrupt handshake with the core
    input  wire logic        VECTOR_ACK,
    output logic             TIMER_IRQ,
    // Baud clocks for serial ports 0..2
    output logic      [2:0]  BAUD_TICK
);

    // Registers
    logic [7:0]  mode_q;
    logic [7:0]  main_q;
    logic [7:0]  cnt_lo_q;
    logic [7:0]  cnt_hi_q;
    logic [7:0]  rld_lo_q;
    logic [7:0]  rld_hi_q;
    logic        ovf_flag_q;
    logic        ext_flag_q;
    logic        div2_q;
    logic [2:0]  baud_q;
    logic [31:0] rdata_q;
    logic [1:0]  st_q;
    logic [1:0]  pre_q;
    logic [2:0]  cp_sync_q;
    logic [2:0]  tp_sync_q;
    logic        cp_lvl_q;
    logic        tp_lvl_q;

    // Next values
    logic [7:0]  cnt_lo_d;
    logic [7:0]  cnt_hi_d;
    logic [7:0]  rld_lo_d;
    logic [7:0]  rld_hi_d;
    logic        ovf_flag_d;
    logic        ext_flag_d;
    logic        cp_lvl_d;
    logic        tp_lvl_d;

    // Glitch filter: level changes once second and third stage agree
    function automatic logic filt(input logic [2:0] s, input logic lvl);
        filt = (s[1] == s[2]) ? s[2] : lvl;
    endfunction

    // Field views
    wire        ovf_sc   = mode_q[`TCR_M_OVF_SC];
    wire        ext_sc   = mode_q[`TCR_M_EXT_SC];
    wire [1:0]  pr_sel   = mode_q[`TCR_M_PR_HI:`TCR_M_PR_LO];
    wire        clk_oe   = mode_q[`TCR_M_OE];
    wire        down_count_enable     = mode_q[`TCR_M_DOWN_COUNT_ENABLE];
    wire [1:0]  ssi      = main_q[`TCR_C_SSI_HI:`TCR_C_SSI_LO];
    wire        exen     = main_q[`TCR_C_EXEN];
    wire        run      = main_q[`TCR_C_RUN];
    wire        cts      = main_q[`TCR_C_CTS];
    wire        cprl     = main_q[`TCR_C_CPRL];
    wire [15:0] count    = {cnt_hi_q, cnt_lo_q};
    wire [15:0] reload   = {rld_hi_q, rld_lo_q};
    wire [15:0] cnt_max  = `TCR_CNT_MAX;

    // Mode decode; capture select is don't-care in baud mode
    tcr_mode_t mode;
    assign mode = (ssi != 2'b00)      ? TCR_BAUD :
                  ({cprl, clk_oe} == 2'b00) ? TCR_RELOAD :
                  ({cprl, clk_oe} == 2'b01) ? TCR_CLKOUT :
                  ({cprl, clk_oe} == 2'b10) ? TCR_CAPTURE :
                                              TCR_STOPPED;
    wire is_baud   = (mode == TCR_BAUD);
    wire is_cap    = (mode == TCR_CAPTURE);
    wire is_clkout = (mode == TCR_CLKOUT);
    wire is_reload = (mode == TCR_RELOAD);
    wire updown    = is_reload && down_count_enable;

    // APB decode
    wire setup    = PSEL && !PENABLE;
    wire wr       = PSEL && PENABLE && PWRITE;
    wire a_mode   = (PADDR == `TCR_OFS_MODE);
    wire a_main   = (PADDR == `TCR_OFS_MAIN);
    wire a_clo    = (PADDR == `TCR_OFS_CNT_LO);
    wire a_chi    = (PADDR == `TCR_OFS_CNT_HI);
    wire a_rlo    = (PADDR == `TCR_OFS_RLD_LO);
    wire a_rhi    = (PADDR == `TCR_OFS_RLD_HI);
    wire mapped   = a_mode || a_main || a_clo || a_chi || a_rlo || a_rhi;
    wire wr_mode  = wr && a_mode;
    wire wr_main  = wr && a_main;
    wire wr_clo   = wr && a_clo;
    wire wr_chi   = wr && a_chi;
    wire [7:0] wb = PWDATA[7:0];

    // Read mux, if/else-if on address
    logic [7:0] rd_mux;
    always_comb begin
        if (a_mode) begin
            rd_mux = {2'b00, mode_q[5:0]};
        end else if (a_main) begin
            rd_mux = {ovf_flag_q, ext_flag_q, main_q[5:0]};
        end else if (a_clo) begin
            rd_mux = cnt_lo_q;
        end else if (a_chi) begin
            rd_mux = cnt_hi_q;
        end else if (a_rlo) begin
            rd_mux = rld_lo_q;
        end else if (a_rhi) begin
            rd_mux = rld_hi_q;
        end else begin
            rd_mux = 8'h00;
        end
    end

    // Zero-wait slave; error only on unmapped address
    assign PREADY  = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !mapped;
    assign PRDATA  = rdata_q;

    // Read data captured in setup, stable through access
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rdata_q <= 32'h0000_0000;
        end else if (setup) begin
            rdata_q <= {24'h00_0000, rd_mux};
        end
    end

    // Control registers; flags live separately
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            mode_q <= `TCR_MODE_RST;
            main_q <= `TCR_MAIN_RST;
        end else begin
            if (wr_mode) begin
                mode_q <= {2'b00, wb[5:0]};
            end
            if (wr_main) begin
                main_q <= {2'b00, wb[5:0]};
            end
        end
    end

    // Pin synchronisers; first stage feeds only the second
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            cp_sync_q <= 3'h7;
            tp_sync_q <= 3'h7;
            cp_lvl_q  <= 1'b1;
            tp_lvl_q  <= 1'b1;
        end else begin
            cp_sync_q <= {cp_sync_q[1:0], COUNT_PIN_IN};
            tp_sync_q <= {tp_sync_q[1:0], TRIGGER_PIN};
            cp_lvl_q  <= cp_lvl_d;
            tp_lvl_q  <= tp_lvl_d;
        end
    end
    assign cp_lvl_d = filt(cp_sync_q, cp_lvl_q);
    assign tp_lvl_d = filt(tp_sync_q, tp_lvl_q);
    wire cp_fall = cp_lvl_q && !cp_lvl_d;
    wire tp_fall = tp_lvl_q && !tp_lvl_d;

    // State time of three clocks, then 1..4 state times per tick
    wire st_end = (st_q == `TCR_OSC_PER_ST - 2'h1);
    wire tick   = st_end && (pre_q == pr_sel);
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            st_q  <= 2'h0;
            pre_q <= 2'h0;
        end else begin
            st_q  <= st_end ? 2'h0 : st_q + 2'h1;
            if (st_end) begin
                pre_q <= tick ? 2'h0 : pre_q + 2'h1;
            end
        end
    end

    // Increment source and gating
    wire src  = cts ? cp_fall : tick;
    wire step = run && src && (mode != TCR_STOPPED);
    wire down = updown && !tp_lvl_q;
    wire ovf  = step && !down && (count == `TCR_CNT_MAX);
    wire unf  = step && down && (count == reload);
    // Trigger event only with external enable set
    wire trig = exen && tp_fall && !updown;
    wire cap  = trig && is_cap;
    wire trl  = trig && (is_reload || is_clkout);

    // Count update: bytes cascade, reloads and software writes
    logic [7:0] lo_inc;
    logic       lo_carry;
    always_comb begin
        lo_inc   = cnt_lo_q + 8'h01;
        lo_carry = (cnt_lo_q == 8'hFF);
        cnt_lo_d = cnt_lo_q;
        cnt_hi_d = cnt_hi_q;
        if (unf) begin
            cnt_lo_d = cnt_max[7:0];
            cnt_hi_d = cnt_max[15:8];
        end else if ((ovf && !is_cap) || trl) begin
            cnt_lo_d = rld_lo_q;
            cnt_hi_d = rld_hi_q;
        end else if (step && down) begin
            cnt_lo_d = cnt_lo_q - 8'h01;
            cnt_hi_d = (cnt_lo_q == 8'h00) ? cnt_hi_q - 8'h01 : cnt_hi_q;
        end else if (step) begin
            cnt_lo_d = lo_inc;
            cnt_hi_d = lo_carry ? cnt_hi_q + 8'h01 : cnt_hi_q;
        end
        if (wr_clo) begin
            cnt_lo_d = wb;
        end
        if (wr_chi) begin
            cnt_hi_d = wb;
        end
    end

    // Capture pair doubles as reload pair
    always_comb begin
        rld_lo_d = rld_lo_q;
        rld_hi_d = rld_hi_q;
        if (cap) begin
            rld_lo_d = cnt_lo_q;
            rld_hi_d = cnt_hi_q;
        end
        if (wr && a_rlo) begin
            rld_lo_d = wb;
        end
        if (wr && a_rhi) begin
            rld_hi_d = wb;
        end
    end

    // Flags: hardware set beats any clear in the same cycle
    wire wrap    = ovf || unf;
    wire ovf_set = wrap && !is_baud;
    wire ext_set = (trig && !updown) || (exen && tp_fall && is_baud);
    wire ovf_clr = (wr_main && !wb[`TCR_C_OVF]) || (VECTOR_ACK && !ovf_sc);
    wire ext_clr = (wr_main && !wb[`TCR_C_EXT]) || (VECTOR_ACK && !ext_sc);
    wire ovf_wr1 = wr_main && wb[`TCR_C_OVF];
    wire ext_wr1 = wr_main && wb[`TCR_C_EXT];
    always_comb begin
        ovf_flag_d = ovf_flag_q;
        if (ovf_clr) begin
            ovf_flag_d = 1'b0;
        end
        if (ovf_set || ovf_wr1) begin
            ovf_flag_d = 1'b1;
        end
        ext_flag_d = ext_flag_q;
        if (ext_clr) begin
            ext_flag_d = 1'b0;
        end
        if (ext_set || ext_wr1) begin
            ext_flag_d = 1'b1;
        end
        if (updown && wrap) begin
            ext_flag_d = !ext_flag_q;
        end
    end

    // Counter state and flags
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            cnt_lo_q   <= 8'h00;
            cnt_hi_q   <= 8'h00;
            rld_lo_q   <= 8'h00;
            rld_hi_q   <= 8'h00;
            ovf_flag_q <= 1'b0;
            ext_flag_q <= 1'b0;
        end else begin
            cnt_lo_q   <= cnt_lo_d;
            cnt_hi_q   <= cnt_hi_d;
            rld_lo_q   <= rld_lo_d;
            rld_hi_q   <= rld_hi_d;
            ovf_flag_q <= ovf_flag_d;
            ext_flag_q <= ext_flag_d;
        end
    end

    // Clock-out divider and one-cycle baud pulses per serial port
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            div2_q <= 1'b0;
            baud_q <= 3'h0;
        end else begin
            if (ovf && is_clkout) begin
                div2_q <= !div2_q;
            end
            baud_q <= 3'h0;
            if (ovf && is_baud) begin
                baud_q[ssi - 2'h1] <= 1'b1;
            end
        end
    end
    assign BAUD_TICK = baud_q;

    // Pin driven only in clock-out with enable and internal source
    wire drive = is_clkout && clk_oe && !cts;
    assign COUNT_PIN_OUT  = div2_q;
    assign COUNT_PIN_OE_N = !drive;

    // Clock-out overflows and the up/down external flag raise no request
    assign TIMER_IRQ = (ovf_flag_q && !is_clkout)
                     || (ext_flag_q && !updown);

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    a_ovf_sets_flag: assert property (ovf_set |=> ovf_flag_q)
        else $error("overflow did not set flag");
    a_baud_no_flag: assert property (
        is_baud && !ovf_flag_q && !wr_main |=> !ovf_flag_q)
        else $error("flag set in baud mode");
    a_sw_hold_flag: assert property (
        ovf_flag_q && ovf_sc && !wr_main |=> ovf_flag_q)
        else $error("overflow flag lost under software control");
    a_capture_copy: assert property (
        cap && !(wr && (a_rlo || a_rhi)) |=> reload == $past(count) && ext_flag_q)
        else $error("capture did not copy count");
    a_reload_ovf: assert property (
        ovf && is_reload && !wr_clo && !wr_chi && !wr |=> count == $past(reload))
        else $error("overflow did not reload");
    a_underflow_max: assert property (
        unf && !wr_clo && !wr_chi |=> count == `TCR_CNT_MAX && ovf_flag_q)
        else $error("underflow did not load FFFF");
    a_updown_irq: assert property (
        updown |-> TIMER_IRQ == (ovf_flag_q && !is_clkout))
        else $error("external flag raised request in up/down");
    a_pin_drive: assert property (
        !COUNT_PIN_OE_N |-> is_clkout && clk_oe)
        else $error("count pin driven outside clock-out");
    a_prescale_gap: assert property (
        tick && pr_sel == 2'h0 && !wr_mode ##1 (!wr_mode) [*2]
            |=> tick && !$past(tick) && !$past(tick, 2))
        else $error("prescale period wrong");

endmodule
`default_nettype wire

// [common/tcr_consts.svh]
// Offsets, field positions and reset values of the capture/reload timer.
// Included by the design and by the bench; definitions only.
`ifndef TCR_CONSTS_SVH
`define TCR_CONSTS_SVH
// APB byte offsets
`define TCR_OFS_MODE    8'h00
`define TCR_OFS_MAIN    8'h04
`define TCR_OFS_CNT_LO  8'h08
`define TCR_OFS_CNT_HI  8'h0C
`define TCR_OFS_RLD_LO  8'h10
`define TCR_OFS_RLD_HI  8'h14
// timer_mode_control fields
`define TCR_M_OVF_SC    5
`define TCR_M_EXT_SC    4
`define TCR_M_PR_HI     3
`define TCR_M_PR_LO     2
`define TCR_M_OE        1
`define TCR_M_DOWN_COUNT_ENABLE      0
// timer_main_control fields
`define TCR_C_OVF       7
`define TCR_C_EXT       6
`define TCR_C_SSI_HI    5
`define TCR_C_SSI_LO    4
`define TCR_C_EXEN      3
`define TCR_C_RUN       2
`define TCR_C_CTS       1
`define TCR_C_CPRL      0
// Reset values and timing
`define TCR_MODE_RST    8'h00
`define TCR_MAIN_RST    8'h00
`define TCR_CNT_MAX     16'hFFFF
`define TCR_OSC_PER_ST  2'h3
`endif

// [common/tcr_pkg.sv]
// Types shared by the capture/reload timer.
// Assumes tcr_consts.svh is on the include path.
package tcr_pkg;
    // One-hot operating modes
    typedef enum logic [4:0] {
        TCR_RELOAD  = 5'h01,
        TCR_CLKOUT  = 5'h02,
        TCR_CAPTURE = 5'h04,
        TCR_STOPPED = 5'h08,
        TCR_BAUD    = 5'h10
    } tcr_mode_t;
endpackage

// [sim/tcr_pin_model.sv]
// Pin-side partner: count pin, trigger pin and the core's vector ack.
// Assumes the bench calls its tasks between register accesses.
`timescale 1ns/100ps
`default_nettype none
module tcr_pin_model (
    // Clock
    input  wire logic clk,
    // Pin levels and handshake
    output logic      count_lvl,
    output logic      trig_lvl,
    output logic      ack
);
    // Idle pins high, ack low from time zero
    initial begin
        count_lvl = 1'b1;
        trig_lvl  = 1'b1;
        ack       = 1'b0;
    end
    // Six clocks low, six high: well past the three-flop synchroniser
    task automatic pulse(input logic trig);
        @(posedge clk);
        if (trig) trig_lvl <= 1'b0; else count_lvl <= 1'b0;
        repeat (6) @(posedge clk);
        if (trig) trig_lvl <= 1'b1; else count_lvl <= 1'b1;
        repeat (6) @(posedge clk);
    endtask
    // Level change, then time for the filtered level to follow
    task automatic set_trig(input logic v);
        @(posedge clk);
        trig_lvl <= v;
        repeat (8) @(posedge clk);
    endtask
    // One-cycle vectoring pulse; the clear lands on the next edge
    task automatic vec_ack;
        @(posedge clk);
        ack <= 1'b1;
        @(posedge clk);
        ack <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// [sim/tb_top.sv]
// Self-checking bench for the capture/reload timer over APB.
// Assumes tcr_pin_model drives the pins; count pin resolved here.
`timescale 1ns/100ps
`default_nettype none
`include "tcr_consts.svh"
module tb_top;
    localparam logic [7:0] MD = `TCR_OFS_MODE;
    localparam logic [7:0] MN = `TCR_OFS_MAIN;
    localparam logic [7:0] CL = `TCR_OFS_CNT_LO;
    localparam logic [7:0] RC = `TCR_OFS_RLD_LO;
    logic        clk, rst, psel, penable, pwrite, err, last_out;
    logic [7:0]  paddr, f;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, cnt_out, cnt_oe_n, irq;
    logic [2:0]  baud;
    wire logic   cnt_lvl, trig_lvl, ack, cnt_pin;
    int          error_cnt, checks_done, tog;
    int          ticks [3];

    tcr_timer tcr_timer_inst (
        .CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .COUNT_PIN_IN(cnt_pin), .COUNT_PIN_OUT(cnt_out),
        .COUNT_PIN_OE_N(cnt_oe_n), .TRIGGER_PIN(trig_lvl), .VECTOR_ACK(ack),
        .TIMER_IRQ(irq), .BAUD_TICK(baud)
    );
    tcr_pin_model tcr_pin_model_inst (
        .clk(clk), .count_lvl(cnt_lvl), .trig_lvl(trig_lvl), .ack(ack)
    );
    // Design owns the pin while its enable is low
    assign cnt_pin = cnt_oe_n ? cnt_lvl : cnt_out;

    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Baud pulses per port and clock-out toggles
    always @(posedge clk) begin
        for (int i = 0; i < 3; i++) if (baud[i] === 1'b1) ticks[i]++;
        if (cnt_out !== last_out) tog++;
        last_out <= cnt_out;
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // Let the write settle before callers look at pins
        @(negedge clk);
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] v);
        apb(1'b1, a, {24'h0, v});
    endtask
    task automatic creg(input string nm, input logic [7:0] a, input logic [7:0] v);
        apb(1'b0, a, 32'h0);
        chk(nm, {24'h0, v}, rd);
    endtask
    // Byte pairs: low byte first, high byte four bytes above
    task automatic c16(input string nm, input logic [7:0] a, input logic [15:0] v);
        creg(nm, a, v[7:0]);
        creg(nm, a + 8'h04, v[15:8]);
    endtask
    // Timer stopped before the pairs are touched
    task automatic setup(input logic [7:0] m, input logic [15:0] c, input logic [15:0] r);
        wreg(MN, 8'h00);
        wreg(MD, m);
        wreg(RC, r[7:0]);
        wreg(RC + 8'h04, r[15:8]);
        wreg(CL, c[7:0]);
        wreg(CL + 8'h04, c[15:8]);
    endtask
    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Hang guard, far beyond the thirteen hundred or so cycles expected
    initial begin
        #(40 * 50000);
        error_cnt++;
        wrap_up();
    end

    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {error_cnt, checks_done, tog, last_out} = '0;
        ticks = '{0, 0, 0};
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        // Reset state and unmapped access
        creg("mode", MD, 8'h00);
        creg("main", MN, 8'h00);
        chk("oe_n", 1, cnt_oe_n);
        apb(1'b1, 8'h18, 32'hFF);
        chk("slverr", 1, err);
        apb(1'b0, 8'h18, 32'h0);
        chk("unmapped", 0, {err, rd} - 33'h1_0000_0000);
        // Run gating, then carry from low into high byte
        setup(8'h00, 16'h00FF, 16'h0000);
        wreg(MN, 8'h02);
        tcr_pin_model_inst.pulse(1'b0);
        c16("count", CL, 16'h00FF);
        wreg(MN, 8'h06);
        tcr_pin_model_inst.pulse(1'b0);
        c16("count", CL, 16'h0100);
        // Up-count overflow reloads and flags
        setup(8'h00, 16'hFFFF, 16'h1234);
        wreg(MN, 8'h06);
        tcr_pin_model_inst.pulse(1'b0);
        c16("count", CL, 16'h1234);
        creg("main", MN, 8'h86);
        chk("irq", 1, irq);
        // Vector clearing against software control, both flags
        for (int i = 0; i < 4; i++) begin
            f = i[0] ? 8'h40 : 8'h80;
            wreg(MD, i[1] ? (f >> 2) : 8'h00);
            wreg(MN, f | 8'h06);
            chk("irq", 1, irq);
            tcr_pin_model_inst.vec_ack();
            creg("main", MN, i[1] ? (f | 8'h06) : 8'h06);
        end
        // Capture ignored without external enable, taken with it
        setup(8'h00, 16'h5678, 16'h0000);
        wreg(MN, 8'h07);
        tcr_pin_model_inst.pulse(1'b1);
        c16("capture", RC, 16'h0000);
        wreg(MN, 8'h0F);
        tcr_pin_model_inst.pulse(1'b1);
        c16("capture", RC, 16'h5678);
        creg("main", MN, 8'h4F);
        // Trigger edge reloads in up auto-reload
        setup(8'h00, 16'h0042, 16'h1111);
        wreg(MN, 8'h0E);
        tcr_pin_model_inst.pulse(1'b1);
        c16("count", CL, 16'h1111);
        creg("main", MN, 8'h4E);
        // Up/down: trigger low counts down to the reload value
        setup(8'h01, 16'h0011, 16'h0010);
        tcr_pin_model_inst.set_trig(1'b0);
        wreg(MN, 8'h06);
        tcr_pin_model_inst.pulse(1'b0);
        c16("count", CL, 16'h0010);
        tcr_pin_model_inst.pulse(1'b0);
        c16("count", CL, 16'hFFFF);
        creg("main", MN, 8'hC6);
        wreg(MN, 8'h46);
        chk("irq", 0, irq);
        tcr_pin_model_inst.set_trig(1'b1);
        tcr_pin_model_inst.pulse(1'b0);
        c16("count", CL, 16'h0010);
        creg("main", MN, 8'h86);
        // Baud generator on each port, capture select set and ignored
        for (int n = 1; n < 4; n++) begin
            setup(8'h00, 16'hFFFF, 16'hABCD);
            wreg(MN, 8'(16 * n + 15));
            ticks = '{0, 0, 0};
            tcr_pin_model_inst.pulse(1'b0);
            c16("count", CL, 16'hABCD);
            for (int i = 0; i < 3; i++) chk("baud_tick", i == n - 1, ticks[i]);
            creg("main", MN, 8'(16 * n + 15));
            tcr_pin_model_inst.pulse(1'b1);
            creg("main", MN, 8'(16 * n + 79));
            c16("count", CL, 16'hABCD);
            c16("reload", RC, 16'hABCD);
        end
        // Clock-out at each prescale: one toggle per 3*(p+1) clocks
        for (int p = 0; p < 4; p++) begin
            setup(8'(2 + 4 * p), 16'hFFFF, 16'hFFFF);
            wreg(MN, 8'h04);
            chk("oe_n", 0, cnt_oe_n);
            repeat (8) @(posedge clk);
            tog = 0;
            repeat (120) @(posedge clk);
            chk("toggles", 1, tog >= 40 / (p + 1) - 1 && tog <= 40 / (p + 1) + 1);
            chk("irq", 0, irq);
        end
        wreg(MD, 8'h00);
        chk("oe_n", 1, cnt_oe_n);
        // Capture select with output enable stops the count
        setup(8'h02, 16'h0010, 16'h0000);
        wreg(MN, 8'h05);
        repeat (40) @(posedge clk);
        c16("stopped", CL, 16'h0010);
        chk("oe_n", 1, cnt_oe_n);
        wrap_up();
    end
endmodule
`default_nettype wire
